// >>> hdl/cgp_pkg.sv
package cgp_pkg;

  // data path widths
  localparam int BYTE_W = 8;
  localparam int SPI_ADDR_W = 7;
  localparam int DEV_HI_W = 5;
  localparam int LOS_CNT = 4;

  // bit positions inside received bytes
  localparam int RW_BIT = 0;
  localparam int SPI_RD_BIT = 7;

  // pin synchroniser: {sel, cs, sclk, data, addr_one, oe_dis, lock, los[3:0]}
  localparam int PIN_CNT = 11;
  // select and chip select rest high, as their pull-ups would leave them
  localparam logic [PIN_CNT-1:0] PIN_RST = 11'h600;

  // status compare waits until the synchronised detectors are real
  localparam int PRIME_STAGES = 3;

  // upper bits of the 7-bit bus address; value is arbitrary
  localparam logic [DEV_HI_W-1:0] DEV_HI_DEF = 5'h0b;

  localparam logic [BYTE_W-1:0] ADDR_STEP = 8'h01;
  localparam logic ACK_LVL = 1'b0;
  localparam logic PULL_ON = 1'b1;
  localparam logic DRIVE_LOW = 1'b0;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_REGADDR,
    ST_WRITE,
    ST_READ,
    ST_IGNORE,
    ST_SPI_CMD,
    ST_SPI_WR,
    ST_SPI_RD
  } cgp_state_type;

endpackage

// >>> hdl/cgp_sync.sv
`timescale 1ns/1ps
module cgp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] stable_ff;

  if (W < 1) begin : g_bad_width
    $error("cgp_sync: width must be at least one");
  end

  // first stage is read by the second stage only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST_VAL;
      stable_ff <= RST_VAL;
    end else begin
      meta_ff <= d;
      stable_ff <= meta_ff;
    end
  end

  assign q = stable_ff;

endmodule

// >>> hdl/cgp_shift.sv
`timescale 1ns/1ps
module cgp_shift #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic clear,
  input wire logic shift_en,
  input wire logic din,
  // result
  output logic [W-1:0] word,
  output logic [$clog2(W)-1:0] bit_cnt,
  output logic done
);

  localparam int CW = $clog2(W);
  localparam logic [CW-1:0] LAST = CW'(W - 1);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [W-1:0] word_ff;
  logic [CW-1:0] cnt_ff;
  logic done_ff;

  if (W < 2) begin : g_bad_width
    $error("cgp_shift: width must be at least two");
  end

  wire at_last = (cnt_ff == LAST);
  wire [CW-1:0] cnt_step = at_last ? '0 : cnt_ff + ONE;
  wire [CW-1:0] nxt_cnt = clear ? '0 : (shift_en ? cnt_step : cnt_ff);
  wire [W-1:0] nxt_word = shift_en ? {word_ff[W-2:0], din} : word_ff;
  wire nxt_done = shift_en & at_last & ~clear;

  // msb first; done marks the edge that completed a whole word
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      word_ff <= '0;
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      word_ff <= nxt_word;
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign word = word_ff;
  assign bit_cnt = cnt_ff;
  assign done = done_ff;

endmodule

// >>> hdl/cgp_host_port.sv
// Function
// - select pin high gives i2c, low spi
// - select pin pulled up, defaults to i2c
// - data pin bidirectional except four-wire spi input
// - second pin: i2c address bit, four-wire spi output
// - host serial clock is bit clock always
// - shared pin: i2c address bit, spi select
// - interrupt pulled low after status change
// - reset low returns everything to defaults
// - clock outputs disabled while reset held
// - disable pin high turns clock outputs off
// - lock output high locked, low unlocked
// - four loss outputs, low on loss
// - disable pin pulled down, outputs enabled
`timescale 1ns/1ps
module cgp_host_port #(
  parameter logic [cgp_pkg::DEV_HI_W-1:0] DEV_ADDR_HI = cgp_pkg::DEV_HI_DEF
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // interface select
  input wire logic i2c_sel_pin,
  output logic i2c_sel_pull_up,
  input wire logic spi_four_wire,
  output logic host_mode_i2c,
  output logic host_busy,
  // serial clock and shared pins
  input wire logic serial_clk_pin,
  input wire logic data_pin_in,
  output logic data_pin_out,
  output logic data_pin_oe,
  input wire logic addr_bit_one_in,
  output logic spi_serial_out,
  output logic addr_bit_one_oe,
  input wire logic addr_bit_zero_cs_n,
  // register map side
  output logic [cgp_pkg::BYTE_W-1:0] reg_addr,
  output logic [cgp_pkg::BYTE_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [cgp_pkg::BYTE_W-1:0] reg_rdata,
  // output control
  input wire logic out_disable_pin,
  output logic out_disable_pull_down,
  output logic clk_outputs_en,
  // detectors and status pins
  input wire logic pll_lock_det,
  input wire logic [cgp_pkg::LOS_CNT-1:0] input_los_det,
  input wire logic irq_clear,
  output logic status_change_irq_n_out,
  output logic status_change_irq_n_oe,
  output logic pll_unlocked_n,
  output logic input0_signal_lost_n,
  output logic input1_signal_lost_n,
  output logic input2_signal_lost_n,
  output logic input3_signal_lost_n
);

  localparam int BW = cgp_pkg::BYTE_W;
  localparam int LW = cgp_pkg::LOS_CNT;
  localparam int CW = $clog2(BW);

  logic [1:0] rst_pipe_ff;
  logic rst_ok_n;
  logic [cgp_pkg::PIN_CNT-1:0] pin_s;
  logic sel_s;
  logic cs_s;
  logic sclk_s;
  logic data_s;
  logic abo_s;
  logic oed_s;
  logic lock_s;
  logic [LW-1:0] los_s;
  logic sclk_prev_ff;
  logic data_prev_ff;
  cgp_pkg::cgp_state_type state_ff;
  cgp_pkg::cgp_state_type nxt_state;
  logic do_ack;
  logic do_rd;
  logic do_wr;
  logic ld_addr;
  logic [BW-1:0] rx_word;
  logic [CW-1:0] bit_cnt;
  logic rx_done;
  logic [BW-1:0] addr_ff;
  logic [BW-1:0] reg_addr_ff;
  logic [BW-1:0] reg_wdata_ff;
  logic reg_wr_ff;
  logic reg_rd_ff;
  logic [BW-1:0] rdata_ff;
  logic [BW-1:0] tx_ff;
  logic drv_ff;
  logic nine_ff;
  logic nine_rise_ff;
  logic ack_want_ff;
  logic ack_ff;
  logic mack_ff;
  logic data_oe_ff;
  logic data_out_ff;
  logic abo_oe_ff;
  logic abo_out_ff;
  logic [cgp_pkg::PRIME_STAGES-1:0] prime_ff;
  logic unlocked_n_ff;
  logic [LW-1:0] los_n_ff;
  logic irq_ff;
  logic clk_en_ff;

  function automatic logic is_spi_state(input cgp_pkg::cgp_state_type s);
    is_spi_state = (s == cgp_pkg::ST_SPI_CMD) || (s == cgp_pkg::ST_SPI_WR) ||
                   (s == cgp_pkg::ST_SPI_RD);
  endfunction

  function automatic logic is_i2c_state(input cgp_pkg::cgp_state_type s);
    is_i2c_state = (s != cgp_pkg::ST_IDLE) && !is_spi_state(s);
  endfunction

  // reset asserts at once, releases through two flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_ff <= '0;
    end else begin
      rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
    end
  end
  assign rst_ok_n = rst_pipe_ff[1];

  cgp_sync #(
    .W(cgp_pkg::PIN_CNT),
    .RST_VAL(cgp_pkg::PIN_RST)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_ok_n),
    .d({i2c_sel_pin, addr_bit_zero_cs_n, serial_clk_pin, data_pin_in,
        addr_bit_one_in, out_disable_pin, pll_lock_det, input_los_det}),
    .q(pin_s)
  );
  assign {sel_s, cs_s, sclk_s, data_s, abo_s, oed_s, lock_s, los_s} = pin_s;

  // pads: pulls are always on, so floating pins read as their defaults
  assign i2c_sel_pull_up = cgp_pkg::PULL_ON;
  assign out_disable_pull_down = cgp_pkg::PULL_ON;

  // mode, bus edges and framing
  wire i2c_mode = sel_s;
  wire sclk_rise = sclk_s & ~sclk_prev_ff;
  wire sclk_fall = ~sclk_s & sclk_prev_ff;
  wire sclk_high = sclk_s & sclk_prev_ff;
  wire i2c_start = i2c_mode & sclk_high & data_prev_ff & ~data_s;
  wire i2c_stop = i2c_mode & sclk_high & ~data_prev_ff & data_s;
  wire spi_sel = ~i2c_mode & ~cs_s;
  wire mode_clash = i2c_mode ? is_spi_state(state_ff) : is_i2c_state(state_ff);
  wire i2c_xfer = is_i2c_state(state_ff) && (state_ff != cgp_pkg::ST_IGNORE);
  // i2c address is {fixed high bits, second pin, shared select pin}
  wire dev_hit = (rx_word[BW-1:1] == {DEV_ADDR_HI, abo_s, cs_s});
  wire [BW-1:0] cmd_addr = {{(BW - cgp_pkg::SPI_ADDR_W){1'b0}},
                            rx_word[cgp_pkg::SPI_ADDR_W-1:0]};
  wire in_cmd = (state_ff == cgp_pkg::ST_SPI_CMD);
  wire [BW-1:0] acc_addr = in_cmd ? cmd_addr : addr_ff;
  wire [BW-1:0] ld_val = in_cmd ? cmd_addr : rx_word;

  // ninth bit of each i2c byte is the acknowledge slot
  wire nine_begin = rx_done & i2c_mode & i2c_xfer;
  wire nine_end = sclk_fall & nine_rise_ff;
  wire frame_edge = i2c_start | i2c_stop;
  wire in_read = (state_ff == cgp_pkg::ST_READ);
  wire i2c_load = nine_end & in_read & (ack_want_ff | mack_ff);
  wire i2c_nack = nine_end & in_read & ~ack_want_ff & ~mack_ff;
  wire spi_load = reg_rd_ff & ~i2c_mode;

  wire shift_clr = frame_edge | (~i2c_mode & cs_s);
  wire shift_en = sclk_rise & (i2c_mode ? ~nine_ff : spi_sel);

  cgp_shift #(
    .W(BW)
  ) u_rx_shift (
    .clk_sys(clk_sys),
    .rst_n(rst_ok_n),
    .clear(shift_clr),
    .shift_en(shift_en),
    .din(data_s),
    .word(rx_word),
    .bit_cnt(bit_cnt),
    .done(rx_done)
  );

  always_comb begin
    nxt_state = state_ff;
    do_ack = 1'b0;
    do_rd = 1'b0;
    do_wr = 1'b0;
    ld_addr = 1'b0;
    if (i2c_start) begin
      nxt_state = cgp_pkg::ST_DEVADDR;
    end else if (i2c_stop || mode_clash || (!i2c_mode && cs_s)) begin
      nxt_state = cgp_pkg::ST_IDLE;
    end else if (spi_sel && state_ff == cgp_pkg::ST_IDLE) begin
      nxt_state = cgp_pkg::ST_SPI_CMD;
    end else if (i2c_nack) begin
      nxt_state = cgp_pkg::ST_IGNORE;
    end else if (rx_done) begin
      case (state_ff)
        cgp_pkg::ST_DEVADDR: begin
          if (dev_hit) begin
            do_ack = 1'b1;
            do_rd = rx_word[cgp_pkg::RW_BIT];
            nxt_state = rx_word[cgp_pkg::RW_BIT] ? cgp_pkg::ST_READ : cgp_pkg::ST_REGADDR;
          end else begin
            nxt_state = cgp_pkg::ST_IGNORE;
          end
        end
        cgp_pkg::ST_REGADDR: begin
          do_ack = 1'b1;
          ld_addr = 1'b1;
          nxt_state = cgp_pkg::ST_WRITE;
        end
        cgp_pkg::ST_WRITE: begin
          do_ack = 1'b1;
          do_wr = 1'b1;
        end
        // prefetch: the next byte is fetched before the master acks
        cgp_pkg::ST_READ: begin
          do_rd = 1'b1;
        end
        cgp_pkg::ST_SPI_CMD: begin
          do_rd = rx_word[cgp_pkg::SPI_RD_BIT];
          ld_addr = ~rx_word[cgp_pkg::SPI_RD_BIT];
          nxt_state = rx_word[cgp_pkg::SPI_RD_BIT] ? cgp_pkg::ST_SPI_RD : cgp_pkg::ST_SPI_WR;
        end
        cgp_pkg::ST_SPI_WR: begin
          do_wr = 1'b1;
        end
        cgp_pkg::ST_SPI_RD: begin
          do_rd = 1'b1;
        end
        default: begin
          nxt_state = state_ff;
        end
      endcase
    end
  end

  wire acc = do_rd | do_wr;
  wire [BW-1:0] nxt_addr = acc ? acc_addr + cgp_pkg::ADDR_STEP : (ld_addr ? ld_val : addr_ff);

  // acknowledge slot bookkeeping
  wire nxt_nine = frame_edge ? 1'b0 : (nine_begin ? 1'b1 : (nine_end ? 1'b0 : nine_ff));
  wire nine_clr = frame_edge | nine_end;
  wire nxt_nine_rise = nine_clr ? 1'b0 : ((sclk_rise & nine_ff) | nine_rise_ff);
  wire nxt_ack_want = nine_begin ? do_ack : ack_want_ff;
  wire ack_go = sclk_fall & nine_ff & ~nine_rise_ff & ack_want_ff;
  wire nxt_ack = nine_clr ? 1'b0 : (ack_go | ack_ff);
  wire mack_smp = sclk_rise & nine_ff;
  wire nxt_mack = nine_begin ? 1'b0 : (mack_smp ? (data_s == cgp_pkg::ACK_LVL) : mack_ff);

  // transmit: load at the i2c slot edge or on the spi read strobe, shift on falls inside a byte
  wire tx_shift = sclk_fall & (bit_cnt != '0);
  wire [BW-1:0] tx_next = tx_shift ? {tx_ff[BW-2:0], 1'b0} : tx_ff;
  wire [BW-1:0] nxt_tx = spi_load ? reg_rdata : (i2c_load ? rdata_ff : tx_next);
  wire drv_clr = i2c_mode ? (rx_done | frame_edge) : cs_s;
  wire nxt_drv = drv_clr ? 1'b0 : (spi_load | i2c_load | drv_ff);
  wire tx_bit = tx_ff[BW-1];

  // open drain on i2c, push-pull on three-wire spi, input on four-wire
  wire i2c_oe = ack_ff | (drv_ff & ~tx_bit);
  wire nxt_data_oe = i2c_mode ? i2c_oe : (drv_ff & ~spi_four_wire);
  wire nxt_data_out = ~i2c_mode & tx_bit;
  wire nxt_abo_oe = spi_sel & spi_four_wire;

  // status: compare only once the detector path holds real values
  wire primed = prime_ff[cgp_pkg::PRIME_STAGES-1];
  wire [LW-1:0] nxt_los_n = ~los_s;
  wire stat_chg = primed & ((lock_s != unlocked_n_ff) | (nxt_los_n != los_n_ff));
  wire nxt_irq = stat_chg | (irq_ff & ~irq_clear);

  always_ff @(posedge clk_sys or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      sclk_prev_ff <= 1'b0;
      data_prev_ff <= 1'b0;
      state_ff <= cgp_pkg::ST_IDLE;
      addr_ff <= '0;
      nine_ff <= 1'b0;
      nine_rise_ff <= 1'b0;
      ack_want_ff <= 1'b0;
      ack_ff <= 1'b0;
      mack_ff <= 1'b0;
      tx_ff <= '0;
      drv_ff <= 1'b0;
    end else begin
      sclk_prev_ff <= sclk_s;
      data_prev_ff <= data_s;
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
      nine_ff <= nxt_nine;
      nine_rise_ff <= nxt_nine_rise;
      ack_want_ff <= nxt_ack_want;
      ack_ff <= nxt_ack;
      mack_ff <= nxt_mack;
      tx_ff <= nxt_tx;
      drv_ff <= nxt_drv;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      reg_rd_ff <= 1'b0;
      reg_wr_ff <= 1'b0;
      reg_addr_ff <= '0;
      reg_wdata_ff <= '0;
      rdata_ff <= '0;
    end else begin
      reg_rd_ff <= do_rd;
      reg_wr_ff <= do_wr;
      reg_addr_ff <= acc ? acc_addr : reg_addr_ff;
      reg_wdata_ff <= do_wr ? rx_word : reg_wdata_ff;
      rdata_ff <= reg_rd_ff ? reg_rdata : rdata_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      data_oe_ff <= 1'b0;
      data_out_ff <= 1'b0;
      abo_oe_ff <= 1'b0;
      abo_out_ff <= 1'b0;
    end else begin
      data_oe_ff <= nxt_data_oe;
      data_out_ff <= nxt_data_out;
      abo_oe_ff <= nxt_abo_oe;
      abo_out_ff <= tx_bit;
    end
  end

  // reset value of the enable keeps clocks off through reset
  always_ff @(posedge clk_sys or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      prime_ff <= '0;
      unlocked_n_ff <= 1'b0;
      los_n_ff <= '0;
      irq_ff <= 1'b0;
      clk_en_ff <= 1'b0;
    end else begin
      prime_ff <= {prime_ff[cgp_pkg::PRIME_STAGES-2:0], 1'b1};
      unlocked_n_ff <= lock_s;
      los_n_ff <= nxt_los_n;
      irq_ff <= nxt_irq;
      clk_en_ff <= ~oed_s;
    end
  end

  assign host_mode_i2c = i2c_mode;
  assign host_busy = (state_ff != cgp_pkg::ST_IDLE);
  assign data_pin_out = data_out_ff;
  assign data_pin_oe = data_oe_ff;
  assign spi_serial_out = abo_out_ff;
  assign addr_bit_one_oe = abo_oe_ff;
  assign reg_addr = reg_addr_ff;
  assign reg_wdata = reg_wdata_ff;
  assign reg_wr = reg_wr_ff;
  assign reg_rd = reg_rd_ff;
  assign clk_outputs_en = clk_en_ff;
  // only ever pulls low; an external pull-up gives the idle high
  assign status_change_irq_n_out = cgp_pkg::DRIVE_LOW;
  assign status_change_irq_n_oe = irq_ff;
  assign pll_unlocked_n = unlocked_n_ff;
  assign input0_signal_lost_n = los_n_ff[0];
  assign input1_signal_lost_n = los_n_ff[1];
  assign input2_signal_lost_n = los_n_ff[2];
  assign input3_signal_lost_n = los_n_ff[3];

endmodule

// >>> dv/cgp_host_port_assertions.sv
`timescale 1ns/1ps
module cgp_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // host port
  input wire logic i2c_sel_pin,
  input wire logic spi_four_wire,
  input wire logic host_mode_i2c,
  input wire logic data_pin_oe,
  input wire logic addr_bit_one_oe,
  input wire logic addr_bit_zero_cs_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  // control and status
  input wire logic out_disable_pin,
  input wire logic clk_outputs_en,
  input wire logic pll_lock_det,
  input wire logic [cgp_pkg::LOS_CNT-1:0] input_los_det,
  input wire logic irq_clear,
  input wire logic status_change_irq_n_oe,
  input wire logic pll_unlocked_n,
  input wire logic input0_signal_lost_n,
  input wire logic input1_signal_lost_n,
  input wire logic input2_signal_lost_n,
  input wire logic input3_signal_lost_n
);
  logic [3:0] up_ff;
  wire logic armed;
  wire logic [3:0] los_n;
  // skip the synchroniser warm-up after each reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      up_ff <= 4'h0;
    end else if (up_ff != 4'hf) begin
      up_ff <= up_ff + 4'h1;
    end
  end
  assign armed = (up_ff == 4'hf);
  assign los_n = {input3_signal_lost_n, input2_signal_lost_n, input1_signal_lost_n,
    input0_signal_lost_n};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_mode_follows_sel: assert property (armed && $stable(i2c_sel_pin) [*4] |->
    host_mode_i2c == i2c_sel_pin) else $error("host mode differs from select pin");
  chk_reset_quiet: assert property ($rose(rst_n) |-> !clk_outputs_en &&
    !status_change_irq_n_oe && !pll_unlocked_n) else $error("outputs active in reset");
  chk_outputs_gate: assert property (armed && $stable(out_disable_pin) [*4] |->
    clk_outputs_en == !out_disable_pin) else $error("clock enable wrong");
  chk_lock_level: assert property (armed && $stable(pll_lock_det) [*4] |->
    pll_unlocked_n == pll_lock_det) else $error("lock output wrong");
  chk_los_level: assert property (armed && $stable(input_los_det) [*4] |->
    los_n == ~input_los_det) else $error("loss outputs wrong");
  chk_irq_on_change: assert property (armed && $changed({pll_unlocked_n, los_n}) |->
    status_change_irq_n_oe) else $error("no interrupt on status change");
  chk_irq_clears: assert property ($stable({pll_lock_det, input_los_det}) [*5] ##0
    (armed && irq_clear) |=> !status_change_irq_n_oe) else $error("interrupt not cleared");
  chk_spi_out_drive: assert property ($fell(addr_bit_zero_cs_n) ##0 (armed &&
    spi_four_wire && !host_mode_i2c) |-> ##[1:4] addr_bit_one_oe) else $error("no out drive");
  chk_i2c_pin_quiet: assert property (armed && host_mode_i2c && $past(host_mode_i2c) |->
    !addr_bit_one_oe) else $error("second pin driven in i2c mode");
  chk_four_wire_in: assert property (armed && spi_four_wire && !host_mode_i2c |->
    !data_pin_oe) else $error("data pin driven in four-wire mode");
  chk_one_access: assert property (reg_wr || reg_rd |=> !reg_wr && !reg_rd)
    else $error("access pulse too long");
  cover property (reg_wr);
  cover property (reg_rd);
  cover property ($rose(status_change_irq_n_oe));
  cover property (armed && !clk_outputs_en);
endmodule

bind cgp_host_port cgp_checker cgp_checker_inst (.clk_sys, .rst_n, .i2c_sel_pin,
  .spi_four_wire, .host_mode_i2c, .data_pin_oe, .addr_bit_one_oe, .addr_bit_zero_cs_n,
  .reg_wr, .reg_rd, .out_disable_pin, .clk_outputs_en, .pll_lock_det, .input_los_det,
  .irq_clear, .status_change_irq_n_oe, .pll_unlocked_n, .input0_signal_lost_n,
  .input1_signal_lost_n, .input2_signal_lost_n, .input3_signal_lost_n);

// >>> dv/cgp_host_model.sv
`timescale 1ns/1ps
module cgp_host_model (
  // clock
  input wire logic clk_sys,
  // host pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  output logic mosi_oe,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    mosi_oe = 1'b0;
  end
  // 200 ns bit clock, low outside frames; long high after each byte for the read turnaround
  task automatic xfer(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi <= tx[i];
      mosi_oe <= drv;
      repeat (6) @(posedge clk_sys);
      rx[i] = miso;
      sclk <= 1'b1;
      repeat (i == 0 ? 8 : 2) @(posedge clk_sys);
      sclk <= 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] cmd, d0, d1, input logic drv,
    output logic [7:0] r0, r1);
    logic [7:0] junk;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    xfer(cmd, 1'b1, junk);
    xfer(d0, drv, r0);
    xfer(d1, drv, r1);
    repeat (4) @(posedge clk_sys);
    cs_n <= 1'b1;
    mosi_oe <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  // i2c write: start, three bytes each with its ack slot, stop; clock left high after
  task automatic i2c_write(input logic [23:0] bytes, output logic [2:0] ack_lvl);
    logic [7:0] junk;
    @(posedge clk_sys);
    mosi_oe <= 1'b0;
    sclk <= 1'b1;
    repeat (8) @(posedge clk_sys);
    mosi <= 1'b0;
    mosi_oe <= 1'b1; // start: data falls while the clock is high
    repeat (8) @(posedge clk_sys);
    sclk <= 1'b0;
    for (int b = 2; b >= 0; b--) begin
      xfer(bytes[b*8 +: 8], 1'b1, junk);
      mosi_oe <= 1'b0;
      repeat (6) @(posedge clk_sys);
      ack_lvl[b] = miso;
      sclk <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sclk <= 1'b0;
    end
    mosi <= 1'b0;
    mosi_oe <= 1'b1;
    repeat (6) @(posedge clk_sys);
    sclk <= 1'b1;
    repeat (6) @(posedge clk_sys);
    mosi_oe <= 1'b0; // stop: data rises while the clock is high
    repeat (6) @(posedge clk_sys);
  endtask
endmodule

// >>> dv/test_host_port_and_status_pins.sv
`timescale 1ns/1ps
module test_host_port_and_status_pins;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic i2c_sel_pin = 1'b0;
  logic spi_four_wire = 1'b1;
  logic out_disable_pin = 1'b0;
  logic pll_lock_det = 1'b0;
  logic [cgp_pkg::LOS_CNT-1:0] input_los_det = 4'h0;
  logic irq_clear = 1'b0;
  logic tgl = 1'b0;
  logic [7:0] r0, r1;
  logic [2:0] acks;
  logic [15:0] wq[$];
  int num_errors = 0;
  int num_checks = 0;
  wire logic sclk, cs_n, mosi, mosi_oe, data_pin_out, data_pin_oe, spi_serial_out;
  wire logic addr_bit_one_oe, i2c_sel_pull_up, out_disable_pull_down, host_mode_i2c;
  wire logic host_busy, reg_wr, reg_rd, clk_outputs_en, status_change_irq_n_out;
  wire logic status_change_irq_n_oe, pll_unlocked_n, input0_signal_lost_n;
  wire logic input1_signal_lost_n, input2_signal_lost_n, input3_signal_lost_n;
  wire logic [cgp_pkg::BYTE_W-1:0] reg_addr, reg_wdata;
  wire logic [cgp_pkg::BYTE_W-1:0] reg_rdata = reg_addr ^ 8'h5a;
  // released lines: pulled high in i2c, a moving pattern otherwise
  wire logic idle_lvl = i2c_sel_pin ? 1'b1 : tgl;
  wire logic data_pin_in = data_pin_oe ? data_pin_out : (mosi_oe ? mosi : idle_lvl);
  wire logic addr_bit_one_in = addr_bit_one_oe ? spi_serial_out : idle_lvl;
  wire logic miso = spi_four_wire ? addr_bit_one_in : data_pin_in;
  wire logic [3:0] los_n = {input3_signal_lost_n, input2_signal_lost_n,
    input1_signal_lost_n, input0_signal_lost_n};

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) tgl <= ~tgl;
  always @(posedge clk_sys) begin
    if (reg_wr === 1'b1) begin
      wq.push_back({reg_addr, reg_wdata});
    end
  end

  cgp_host_port cgp_host_port_inst (.clk_sys, .rst_n, .i2c_sel_pin, .i2c_sel_pull_up,
    .spi_four_wire, .host_mode_i2c, .host_busy, .serial_clk_pin(sclk), .data_pin_in,
    .data_pin_out, .data_pin_oe, .addr_bit_one_in, .spi_serial_out, .addr_bit_one_oe,
    .addr_bit_zero_cs_n(cs_n), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .out_disable_pin, .out_disable_pull_down, .clk_outputs_en, .pll_lock_det,
    .input_los_det, .irq_clear, .status_change_irq_n_out, .status_change_irq_n_oe,
    .pll_unlocked_n, .input0_signal_lost_n, .input1_signal_lost_n, .input2_signal_lost_n,
    .input3_signal_lost_n);
  cgp_host_model cgp_host_model_inst (.clk_sys, .sclk, .cs_n, .mosi, .mosi_oe, .miso);

  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 64; i++) begin
      @(posedge clk_sys);
      if (host_busy === 1'b0) begin
        return;
      end
    end
    num_errors++;
    $display("[ERR] host_busy expected 0 seen %b", host_busy);
    results();
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    tick(10);
    check("clk_outputs_en", 0, clk_outputs_en);
    check("irq_oe", 0, status_change_irq_n_oe);
    check("pll_unlocked_n", 0, pll_unlocked_n);
    check("host_mode_i2c", 1, host_mode_i2c);
    rst_n <= 1'b1;
    tick(20);
  endtask
  task automatic clear_irq();
    @(posedge clk_sys);
    irq_clear <= 1'b1;
    @(posedge clk_sys);
    irq_clear <= 1'b0;
    tick(2);
    check("irq_oe", 0, status_change_irq_n_oe);
  endtask

  initial begin
    do_reset();
    check("sel_pull_up", 1, i2c_sel_pull_up);
    check("dis_pull_down", 1, out_disable_pull_down);
    check("irq_n_out", 0, status_change_irq_n_out);
    check("host_mode_i2c", 0, host_mode_i2c);
    check("clk_outputs_en", 1, clk_outputs_en);
    $display("test reset done");
    cgp_host_model_inst.frame(8'h12, 8'ha5, 8'h3c, 1'b1, r0, r1);
    wait_idle();
    check("wr_count", 2, wq.size());
    check("wr0", 16'h12a5, wq[0]);
    check("wr1", 16'h133c, wq[1]);
    cgp_host_model_inst.frame(8'ha0, 8'h00, 8'h00, 1'b1, r0, r1);
    wait_idle();
    check("rd4_0", 8'h20 ^ 8'h5a, r0);
    check("rd4_1", 8'h21 ^ 8'h5a, r1);
    spi_four_wire <= 1'b0;
    cgp_host_model_inst.frame(8'hc0, 8'h00, 8'h00, 1'b0, r0, r1);
    wait_idle();
    check("rd3_0", 8'h40 ^ 8'h5a, r0);
    check("rd3_1", 8'h41 ^ 8'h5a, r1);
    $display("test spi done");
    pll_lock_det <= 1'b1;
    tick(5);
    check("pll_unlocked_n", 1, pll_unlocked_n);
    check("irq_oe", 1, status_change_irq_n_oe);
    clear_irq();
    for (int i = 0; i < 4; i++) begin
      input_los_det <= 4'h1 << i;
      tick(5);
      check("los_n", 4'(~(4'h1 << i)), los_n);
      check("irq_oe", 1, status_change_irq_n_oe);
      clear_irq();
    end
    pll_lock_det <= 1'b0;
    input_los_det <= 4'h0;
    tick(5);
    check("pll_unlocked_n", 0, pll_unlocked_n);
    check("los_n", 4'hf, los_n);
    clear_irq();
    out_disable_pin <= 1'b1;
    tick(5);
    check("clk_outputs_en", 0, clk_outputs_en);
    out_disable_pin <= 1'b0;
    tick(5);
    check("clk_outputs_en", 1, clk_outputs_en);
    $display("test status done");
    i2c_sel_pin <= 1'b1;
    tick(5);
    check("host_mode_i2c", 1, host_mode_i2c);
    cgp_host_model_inst.frame(8'h05, 8'h77, 8'h77, 1'b1, r0, r1);
    tick(20);
    check("wr_count", 2, wq.size());
    // both address pins read high here; write bit low
    cgp_host_model_inst.i2c_write({cgp_pkg::DEV_HI_DEF, 3'b110, 8'h30, 8'h9c}, acks);
    wait_idle();
    check("i2c_ack", 3'b000, acks);
    check("wr_count", 3, wq.size());
    check("wr2", 16'h309c, wq[2]);
    pll_lock_det <= 1'b1;
    do_reset();
    check("irq_oe", 0, status_change_irq_n_oe);
    check("pll_unlocked_n", 1, pll_unlocked_n);
    $display("test mode and reset done");
    results();
  end
endmodule
